// ---- range_pkg.sv ----
// Constants shared by the group B input range register block.
package range_pkg;

	// APB geometry and register indices; byte address is four times the index.
	localparam int          APB_ADDR_WIDTH = 12;
	localparam int          APB_DATA_WIDTH = 32;
	localparam logic [5:0]  LOWER_INDEX    = 6'h06;
	localparam logic [5:0]  UPPER_INDEX    = 6'h07;
	localparam logic [11:0] LOWER_BYTE_ADDR = {4'h0, LOWER_INDEX, 2'h0};
	localparam logic [11:0] UPPER_BYTE_ADDR = {4'h0, UPPER_INDEX, 2'h0};

	// Field positions within the 16-bit register word.
	localparam int DIR_BIT    = 15;
	localparam int ADDR_MSB   = 14;
	localparam int ADDR_LSB   = 9;
	localparam int RSVD_BIT   = 8;
	localparam int RANGE_MSB  = 7;
	localparam int CODE_WIDTH = 2;
	localparam int CHANNELS   = 4;

	// Values after reset.
	localparam logic [7:0]  RANGE_RESET = 8'hFF;
	localparam logic [15:0] LOWER_RESET = 16'h0CFF;
	localparam logic [15:0] UPPER_RESET = 16'h0EFF;

	// Span codes and their one-hot decode {10 V, 5 V, 2.5 V}.
	localparam logic [1:0] SPAN_10V_LOW  = 2'h0;
	localparam logic [1:0] SPAN_2V5      = 2'h1;
	localparam logic [1:0] SPAN_5V       = 2'h2;
	localparam logic [1:0] SPAN_10V_HIGH = 2'h3;
	localparam logic [2:0] ONEHOT_10V    = 3'h4;
	localparam logic [2:0] ONEHOT_5V     = 3'h2;
	localparam logic [2:0] ONEHOT_2V5    = 3'h1;

endpackage

// ---- range_cell.sv ----
// One self-addressed range register holding four 2-bit span codes.
`timescale 1ns/1ps
`default_nettype none
module range_cell
	import range_pkg::*;
#(
	parameter logic [5:0] SELF_ADDR = LOWER_INDEX
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        wr_en,
	input  wire logic [15:0] wr_word,
	output var  logic [7:0]  ranges
);

	typedef struct packed {
		logic [7:0] ranges;
	} cell_state_t;

	cell_state_t state;
	cell_state_t next_state;

	////////////////////////////////////////////////////////////////////////////////
	always_comb begin
		next_state = state;
		// Only a write-direction word naming this register changes the codes.
		if (wr_en && wr_word[DIR_BIT] && wr_word[ADDR_MSB:ADDR_LSB] == SELF_ADDR) begin
			next_state.ranges = wr_word[RANGE_MSB:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state.ranges <= RANGE_RESET;
		end else begin
			state <= next_state;
		end
	end

	assign ranges = state.ranges;

endmodule
`default_nettype wire

// ---- group_b_range_regs.sv ----
// APB register bank holding the group B input range codes.
// Behaviour
// - bit 15 of a word selects direction, 0 read, 1 write.
// - bits 14 to 9 carry the target register address.
// - each register reads back its own address, 6 lower, 7 upper.
// - upper register sits at index 7 and resets to 0xEFF.
// - bit 8 is reserved and always reads zero.
// - span codes 00 and 11 give 10 V, 01 gives 2.5 V, 10 gives 5 V.
// - lower register bits 7..0 hold channels three..zero, reset 11b each.
// - upper register bits 7..0 hold channels seven..four, reset 11b each.
// - lower register sits at index 6 and resets to 0xCFF.
//
// Added by the designer: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module group_b_range_regs
	import range_pkg::*;
#(
	parameter int DATA_WIDTH = APB_DATA_WIDTH
) (
	input  wire logic                      pclk,
	input  wire logic                      presetn,
	input  wire logic                      psel,
	input  wire logic                      penable,
	input  wire logic                      pwrite,
	input  wire logic [APB_ADDR_WIDTH-1:0] paddr,
	input  wire logic [DATA_WIDTH-1:0]     pwdata,
	input  wire logic [DATA_WIDTH/8-1:0]   pstrb,
	output var  logic                      pready,
	output var  logic [DATA_WIDTH-1:0]     prdata,
	output var  logic                      pslverr,
	output var  logic [1:0]                b_input0_span_code,
	output var  logic [1:0]                b_input1_span_code,
	output var  logic [1:0]                b_input2_span_code,
	output var  logic [1:0]                b_input3_span_code,
	output var  logic [1:0]                b_input4_span_code,
	output var  logic [1:0]                b_input5_span_code,
	output var  logic [1:0]                b_input6_span_code,
	output var  logic [1:0]                b_input7_span_code,
	output var  logic [23:0]               b_span_onehot
);

	if (DATA_WIDTH != 32) begin : g_width_check
		$error("group_b_range_regs supports only a 32-bit APB data bus.");
	end

	typedef struct packed {
		logic        pready;
		logic [31:0] prdata;
		logic        pslverr;
		logic [23:0] onehot;
		logic        booted;
	} bank_state_t;

	bank_state_t state;
	bank_state_t next_state;

	logic [7:0]  lower_ranges;
	logic [7:0]  upper_ranges;
	logic [15:0] lower_word;
	logic [15:0] upper_word;
	logic        hit_lower;
	logic        hit_upper;
	logic        access;
	logic        wr_en;
	logic [15:0] cmd_word;

	////////////////////////////////////////////////////////////////////////////////
	// Span decode.

	function automatic logic [2:0] span_onehot(input logic [1:0] code);
		logic [2:0] result;
		result = ONEHOT_10V;
		case (code)
			SPAN_10V_LOW:  result = ONEHOT_10V;
			SPAN_2V5:      result = ONEHOT_2V5;
			SPAN_5V:       result = ONEHOT_5V;
			SPAN_10V_HIGH: result = ONEHOT_10V;
			default:       result = ONEHOT_10V;
		endcase
		return result;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Address decode and write strobe.

	assign hit_lower = (paddr == LOWER_BYTE_ADDR);
	assign hit_upper = (paddr == UPPER_BYTE_ADDR);
	assign access    = psel && penable;
	assign cmd_word  = pwdata[15:0];
	// The command word spans both low byte lanes, so both must be enabled.
	assign wr_en     = access && pwrite && state.pready && (hit_lower || hit_upper)
		&& (pstrb[1:0] == 2'h3);

	// Read words: fixed self address, reserved bit zero, direction reads zero.
	assign lower_word = {1'b0, LOWER_INDEX, 1'b0, lower_ranges};
	assign upper_word = {1'b0, UPPER_INDEX, 1'b0, upper_ranges};

	range_cell #(
		.SELF_ADDR (LOWER_INDEX)
	) group_b_lower_channel_ranges (
		.pclk    (pclk),
		.presetn (presetn),
		.wr_en   (wr_en),
		.wr_word (cmd_word),
		.ranges  (lower_ranges)
	);

	range_cell #(
		.SELF_ADDR (UPPER_INDEX)
	) group_b_upper_channel_ranges (
		.pclk    (pclk),
		.presetn (presetn),
		.wr_en   (wr_en),
		.wr_word (cmd_word),
		.ranges  (upper_ranges)
	);

	////////////////////////////////////////////////////////////////////////////////
	// APB answer: one wait state, then pready with registered data.

	always_comb begin
		next_state         = state;
		next_state.booted  = 1'b1;
		next_state.pready  = access && !state.pready;
		next_state.pslverr = 1'b0;
		next_state.prdata  = 32'h0000_0000;
		if (access && !state.pready) begin
			next_state.pslverr = !(hit_lower || hit_upper);
			if (!pwrite && hit_lower) begin
				next_state.prdata = {16'h0000, lower_word};
			end else if (!pwrite && hit_upper) begin
				next_state.prdata = {16'h0000, upper_word};
			end
		end
		for (int i = 0; i < CHANNELS; i++) begin
			next_state.onehot[3*i +: 3]      = span_onehot(lower_ranges[2*i +: 2]);
			next_state.onehot[12 + 3*i +: 3] = span_onehot(upper_ranges[2*i +: 2]);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state.pready  <= 1'b0;
			state.prdata  <= 32'h0000_0000;
			state.pslverr <= 1'b0;
			state.onehot  <= {8{ONEHOT_10V}};
			state.booted  <= 1'b0;
		end else begin
			state <= next_state;
		end
	end

	assign pready             = state.pready;
	assign prdata             = state.prdata;
	assign pslverr            = state.pslverr;
	assign b_span_onehot      = state.onehot;
	assign b_input0_span_code = lower_ranges[1:0];
	assign b_input1_span_code = lower_ranges[3:2];
	assign b_input2_span_code = lower_ranges[5:4];
	assign b_input3_span_code = lower_ranges[7:6];
	assign b_input4_span_code = upper_ranges[1:0];
	assign b_input5_span_code = upper_ranges[3:2];
	assign b_input6_span_code = upper_ranges[5:4];
	assign b_input7_span_code = upper_ranges[7:6];

	////////////////////////////////////////////////////////////////////////////////
	// Checks.

	dir_read_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_en && !cmd_word[DIR_BIT]) |=> $stable(lower_ranges) && $stable(upper_ranges))
		else $error("Read-direction word changed a range register.");

	addr_select_a: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_en && cmd_word[DIR_BIT] && cmd_word[ADDR_MSB:ADDR_LSB] == UPPER_INDEX)
		|=> $stable(lower_ranges))
		else $error("Write aimed at the upper register touched the lower one.");

	self_addr_a: assert property (@(posedge pclk) disable iff (!presetn)
		(access && !pwrite && hit_upper && !state.pready)
		|=> pready && prdata[ADDR_MSB:ADDR_LSB] == UPPER_INDEX)
		else $error("Upper register did not report its own address.");

	upper_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
		!state.booted |-> upper_word == UPPER_RESET)
		else $error("Upper register reset value is wrong.");

	reserved_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
		pready |-> !prdata[RSVD_BIT] && !prdata[DIR_BIT])
		else $error("Reserved or direction bit read back as one.");

	span_decode_a: assert property (@(posedge pclk) disable iff (!presetn)
		(lower_ranges[1:0] == SPAN_2V5) |=> b_span_onehot[2:0] == ONEHOT_2V5)
		else $error("Channel zero span decode is wrong.");

	lower_write_a: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_en && cmd_word[DIR_BIT] && cmd_word[ADDR_MSB:ADDR_LSB] == LOWER_INDEX)
		|=> lower_ranges == $past(pwdata[7:0])
		##1 b_span_onehot[2:0] == span_onehot(lower_ranges[1:0]))
		else $error("Lower register write did not land.");

	upper_write_a: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_en && cmd_word[DIR_BIT] && cmd_word[ADDR_MSB:ADDR_LSB] == UPPER_INDEX)
		|=> upper_ranges == $past(pwdata[7:0]))
		else $error("Upper register write did not land.");

	lower_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
		!state.booted |-> lower_word == LOWER_RESET)
		else $error("Lower register reset value is wrong.");

	field_fixed_a: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_en && cmd_word[ADDR_MSB:ADDR_LSB] != LOWER_INDEX
			&& cmd_word[ADDR_MSB:ADDR_LSB] != UPPER_INDEX)
		|=> $stable(lower_ranges) && $stable(upper_ranges))
		else $error("Write with a foreign address field changed a register.");

endmodule
`default_nettype wire

// ---- apb_host.sv ----
// APB host model that issues single register transfers to the range bank.
`timescale 1ns/1ps
`default_nettype none
module apb_host (
	input  wire logic        pclk,
	input  wire logic        pready,
	output var  logic        psel,
	output var  logic        penable,
	output var  logic        pwrite,
	output var  logic [11:0] paddr,
	output var  logic [31:0] pwdata,
	output var  logic [3:0]  pstrb
);
	initial begin
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 12'h000;
		pwdata = 32'h00000000;
		pstrb = 4'hF;
	end

	// The request holds until pready is seen high; released lines then show inverted values.
	task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		// Read just after each rising edge, pready shows the value sampled at that edge.
		do @(posedge pclk); while (pready !== 1'h1);
		psel <= 1'h0;
		penable <= 1'h0;
		paddr <= ~a;
		pwdata <= ~d;
	endtask
endmodule
`default_nettype wire

// ---- tb.sv ----
// Self-checking bench for the group B range register bank.
`timescale 1ns/1ps
`default_nettype none
module tb;
	import range_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [3:0]  pstrb;
	logic [1:0]  code [8];
	logic [23:0] onehot;
	logic [7:0]  lo = RANGE_RESET, up = RANGE_RESET;
	logic [32:0] q [$];
	logic [32:0] e;
	int          num_errors = 0, checks_done = 0;
	integer      seed = 32'h5dffc8ab;

	initial begin
		pclk = 1'h0;
		forever #2.5 pclk = ~pclk;
	end
	initial begin
		presetn = 1'h0;
		repeat (2) @(posedge pclk);
		presetn <= 1'h1;
	end

	apb_host host (.pclk(pclk), .pready(pready), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb));
	group_b_range_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .b_input0_span_code(code[0]),
		.b_input1_span_code(code[1]), .b_input2_span_code(code[2]),
		.b_input3_span_code(code[3]), .b_input4_span_code(code[4]),
		.b_input5_span_code(code[5]), .b_input6_span_code(code[6]),
		.b_input7_span_code(code[7]), .b_span_onehot(onehot));

	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [2:0] dec(input logic [1:0] c);
		return (c == 2'h1) ? ONEHOT_2V5 : (c == 2'h2) ? ONEHOT_5V : ONEHOT_10V;
	endfunction

	task automatic chk(input string n, input logic [32:0] s, input logic [32:0] x);
		checks_done++;
		if (s !== x) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", n, x, s);
		end
	endtask

	always @(negedge pclk) begin
		if (pready === 1'h1) begin
			e = q.pop_front();
			chk("apb answer", {pslverr, prdata}, e);
		end
	end

	// The field f is the direction bit and the address field; bit 8 is always written as one.
	task automatic acc(input logic [11:0] a, input logic w, input logic [6:0] f, input logic [7:0] d);
		logic m;
		logic u;
		m = (a == LOWER_BYTE_ADDR) || (a == UPPER_BYTE_ADDR);
		u = (a == UPPER_BYTE_ADDR);
		if (w || !m)
			q.push_back({!m, 32'h00000000});
		else
			q.push_back({17'h00000, 1'h0, u ? UPPER_INDEX : LOWER_INDEX, 1'h0, u ? up : lo});
		host.xfer(a, w, {16'h0000, f, 1'h1, d});
		if (w && m && f == {1'h1, LOWER_INDEX})
			lo = d;
		if (w && m && f == {1'h1, UPPER_INDEX})
			up = d;
	endtask

	task automatic outs(input string n);
		logic [15:0] v;
		repeat (2) @(posedge pclk);
		v = {up, lo};
		for (int i = 0; i < 8; i++) begin
			chk("span code", {31'h0, code[i]}, {31'h0, v[2*i+:2]});
			chk("span decode", {30'h0, onehot[3*i+:3]}, {30'h0, dec(v[2*i+:2])});
		end
		$display("test %s done", n);
	endtask

	task automatic summarize;
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		@(posedge presetn);
		outs("reset");
		acc(LOWER_BYTE_ADDR, 1'h0, 7'h00, 8'h00);
		acc(UPPER_BYTE_ADDR, 1'h0, 7'h00, 8'h00);
		acc(LOWER_BYTE_ADDR, 1'h1, {1'h1, LOWER_INDEX}, 8'h39);
		acc(LOWER_BYTE_ADDR, 1'h1, {1'h0, UPPER_INDEX}, 8'h00);
		acc(LOWER_BYTE_ADDR, 1'h1, {1'h1, UPPER_INDEX}, 8'hE4);
		acc(UPPER_BYTE_ADDR, 1'h1, {1'h1, 6'h05}, 8'h00);
		acc(12'h020, 1'h1, {1'h1, LOWER_INDEX}, 8'h00);
		acc(12'h020, 1'h0, 7'h00, 8'h00);
		acc(LOWER_BYTE_ADDR, 1'h0, 7'h00, 8'h00);
		acc(UPPER_BYTE_ADDR, 1'h0, 7'h00, 8'h00);
		outs("directed");
		repeat (12) begin
			acc($random(seed) & 1 ? UPPER_BYTE_ADDR : LOWER_BYTE_ADDR, 1'h1,
				{1'h1, LOWER_INDEX + 6'($random(seed) & 1)}, 8'($random(seed)));
			acc($random(seed) & 1 ? UPPER_BYTE_ADDR : LOWER_BYTE_ADDR, 1'h0, 7'h00, 8'h00);
		end
		outs("random");
		summarize;
	end

	initial begin
		#20000;
		num_errors++;
		summarize;
	end
endmodule
`default_nettype wire
